// ### hdl/vcarb_pkg.sv
/*
 * Constants for the port configuration slice: register offsets, field
 * positions, reset values and fixed capability values.
 * Assumes byte addresses on a 12-bit configuration offset.
 */
package vcarb_pkg;

    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_IRQ_STATE = 12'h0F4;
    localparam logic [11:0] OFS_CFG_PTR   = 12'h0F8;
    localparam logic [11:0] OFS_CFG_WIN   = 12'h0FC;
    localparam logic [11:0] OFS_VC_HDR    = 12'h100;
    localparam logic [11:0] OFS_PORT_CAP  = 12'h104;
    localparam logic [11:0] OFS_RES_CAP   = 12'h110;
    localparam logic [11:0] OFS_RES_CTL   = 12'h114;
    localparam logic [11:0] OFS_RES_STATE = 12'h118;
    localparam logic [11:0] OFS_TBL_LOW   = 12'h120;
    localparam logic [11:0] OFS_TBL_HIGH  = 12'h124;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int PTR_REG_LSB      = 2;
    localparam int PTR_EXTENDED_REGISTER_NUMBER_MSB     = 11;
    localparam int CAP_ID_LSB       = 0;
    localparam int CAP_VER_LSB      = 16;
    localparam int CAP_NEXT_LSB     = 20;
    localparam int ENTRY_SIZE_LSB   = 10;
    localparam int TBL_OFFSET_LSB   = 24;
    localparam int LOAD_BIT         = 16;
    localparam int ARB_SEL_LSB      = 17;
    localparam int CHAN_ID_LSB      = 24;
    localparam int CHAN_EN_BIT      = 31;
    localparam int FLOW_PEND_BIT    = 1;

    // ------------------------------------------------------------------
    // Fixed values and reset values.
    // ------------------------------------------------------------------
    localparam logic [15:0] CAP_ID_VAL      = 16'h0002;
    localparam logic [3:0]  CAP_VER_VAL     = 4'h1;
    localparam logic [11:0] CAP_NEXT_VAL    = 12'h000;
    localparam logic [1:0]  ENTRY_SIZE_VAL  = 2'h1;
    localparam logic [2:0]  CHAN_ID_VAL     = 3'h0;
    localparam logic [7:0]  ARB_CAP_RST     = 8'h01;
    localparam logic [7:0]  TBL_OFFSET_RST  = 8'h00;
    localparam logic [7:0]  TC_MAP_RST      = 8'hFF;
    localparam logic [2:0]  ARB_SEL_RST     = 3'h0;
    localparam logic [31:0] TBL_RST         = 32'h0000_0000;
    localparam logic [9:0]  PTR_RST         = 10'h000;
    localparam logic [1:0]  PORT_RESERVED   = 2'h3;

endpackage : vcarb_pkg

// ### hdl/vcarb_phase_arbiter.sv
/*
 * Port arbiter that steps through a shadow copy of the phase table.
 * Assumes the table and the load pulse come from the register slice in
 * the same clock domain.
 */
`timescale 1ns/100ps
module vcarb_phase_arbiter
    import vcarb_pkg::*;
#(
    parameter int          NUM_PHASES = 32,
    parameter logic [1:0]  EGRESS_ID  = 2'h0
) (
    // Clock and reset.
    input  wire logic                      clk_sys,
    input  wire logic                      sys_rst,
    // Table load.
    input  wire logic [2*NUM_PHASES-1:0]   table_words,
    input  wire logic                      load_req,
    output logic                           load_done,
    // Arbitration.
    input  wire logic                      arb_step,
    output logic [1:0]                     grant_id,
    output logic                           grant_valid
);

    localparam int PW = $clog2(NUM_PHASES);

    initial begin
        if (NUM_PHASES < 2 || (NUM_PHASES & (NUM_PHASES - 1)) != 0)
            $error("NUM_PHASES must be a power of two of at least 2.");
    end

    logic [2*NUM_PHASES-1:0] shadow_reg;
    logic [PW-1:0]           ptr_reg;
    logic [PW-1:0]           hit_idx;
    logic                    hit_found;

    // ------------------------------------------------------------------
    // Next usable phase at or after the pointer, found in zero time.
    // ------------------------------------------------------------------
    always_comb begin
        logic [PW-1:0] idx;
        logic [1:0]    id;
        idx       = '0;
        id        = '0;
        hit_idx   = ptr_reg;
        hit_found = 1'b0;
        for (int i = 0; i < NUM_PHASES; i++) begin
            idx = ptr_reg + PW'(i);
            id  = shadow_reg[2*idx +: 2];
            if (!hit_found && id != PORT_RESERVED && id != EGRESS_ID) begin
                hit_found = 1'b1;
                hit_idx   = idx;
            end
        end
    end

    // ------------------------------------------------------------------
    // Atomic load of the shadow table.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            shadow_reg <= '0;
            load_done  <= 1'b0;
        end else begin
            load_done <= load_req;
            if (load_req)
                shadow_reg <= table_words;
        end
    end

    // ------------------------------------------------------------------
    // Phase walk and grant.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_reg     <= '0;
            grant_id    <= 2'h0;
            grant_valid <= 1'b0;
        end else if (load_req) begin
            ptr_reg     <= '0;
            grant_valid <= 1'b0;
        end else if (arb_step) begin
            grant_id    <= shadow_reg[2*hit_idx +: 2];
            grant_valid <= hit_found;
            ptr_reg     <= hit_idx + PW'(1);
        end else begin
            grant_valid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_grant_legal: assert property (grant_valid |->
        grant_id != PORT_RESERVED && grant_id != EGRESS_ID)
        else $error("Grant names an invalid port.");
    a_load_atomic: assert property (load_req |=>
        shadow_reg == $past(table_words) && load_done)
        else $error("Shadow table not loaded whole.");

    c_grant_seen: cover property (arb_step ##1 grant_valid);

endmodule : vcarb_phase_arbiter

// ### hdl/vcarb_cfg_regs.sv
/*
 * Configuration register slice of one switch port: legacy interrupt
 * state, indirect access pair, virtual channel capability and the
 * phase table, plus the port arbiter that the table feeds.
 * Assumes one request per cycle on the configuration port, synchronous
 * to clk_sys, answered one cycle later.
 */
`timescale 1ns/100ps
module vcarb_cfg_regs
    import vcarb_pkg::*;
#(
    parameter logic [1:0] EGRESS_ID = 2'h0
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Configuration access port.
    input  wire logic        cfg_req,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_from_smbus,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ack,
    output logic [31:0]      cfg_rdata,
    // Lock for lockable-writable fields.
    input  wire logic        cfg_lock,
    // Port state inputs.
    input  wire logic [3:0]  intx_state,
    input  wire logic        flow_init_busy,
    // Arbiter.
    input  wire logic        arb_step,
    output logic [1:0]       arb_grant_id,
    output logic             arb_grant_valid
);

    logic [3:0]  irq_reg;
    logic        flow_pend_reg;
    logic [9:0]  ptr_reg;
    logic [7:0]  arb_cap_reg;
    logic [7:0]  tbl_ofs_reg;
    logic [7:1]  tc_map_reg;
    logic [2:0]  arb_sel_reg;
    logic [31:0] tbl_low_reg;
    logic [31:0] tbl_high_reg;
    logic        tbl_pend_reg;
    logic        load_reg;
    logic        load_done;

    logic [11:0] tgt_addr;
    logic        win_hit;
    logic        eff_wr;
    logic [11:0] eff_addr;
    logic [31:0] eff_mask;
    logic [31:0] eff_data;
    logic        tbl_written;
    logic [31:0] ptr_next;
    logic [31:0] cap_next;
    logic [31:0] ctl_next;

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++)
            m[8*b +: 8] = {8{be[b]}};
        return m;
    endfunction : be_mask

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        return (old_v & ~m) | (new_v & m);
    endfunction : merge

    function automatic logic [31:0] reg_read(input logic [11:0] a);
        logic [31:0] v;
        v = '0;
        if (a == OFS_IRQ_STATE) begin
            v[3:0] = irq_reg;
        end else if (a == OFS_CFG_PTR) begin
            v[PTR_EXTENDED_REGISTER_NUMBER_MSB:PTR_REG_LSB] = ptr_reg;
        end else if (a == OFS_VC_HDR) begin
            v[CAP_ID_LSB +: 16]  = CAP_ID_VAL;
            v[CAP_VER_LSB +: 4]  = CAP_VER_VAL;
            v[CAP_NEXT_LSB +: 12] = CAP_NEXT_VAL;
        end else if (a == OFS_PORT_CAP) begin
            v[ENTRY_SIZE_LSB +: 2] = ENTRY_SIZE_VAL;
        end else if (a == OFS_RES_CAP) begin
            v[7:0] = arb_cap_reg;
            v[TBL_OFFSET_LSB +: 8] = tbl_ofs_reg;
        end else if (a == OFS_RES_CTL) begin
            v[7:0] = {tc_map_reg, 1'b1};
            v[ARB_SEL_LSB +: 3] = arb_sel_reg;
            v[CHAN_ID_LSB +: 3] = CHAN_ID_VAL;
            v[CHAN_EN_BIT] = 1'b1;
        end else if (a == OFS_RES_STATE) begin
            v[0] = tbl_pend_reg;
            v[FLOW_PEND_BIT] = flow_pend_reg;
        end else if (a == OFS_TBL_LOW) begin
            v = tbl_low_reg;
        end else if (a == OFS_TBL_HIGH) begin
            v = tbl_high_reg;
        end
        return v;
    endfunction : reg_read

    // ------------------------------------------------------------------
    // Indirect access steering.
    // ------------------------------------------------------------------
    always_comb begin
        tgt_addr = {ptr_reg, 2'b00};
        win_hit  = cfg_req && cfg_addr == OFS_CFG_WIN;
        eff_mask = be_mask(cfg_be);
        eff_data = cfg_wdata;
        eff_addr = cfg_addr;
        eff_wr   = cfg_req && cfg_wr;
        if (win_hit) begin
            eff_addr = tgt_addr;
            if (cfg_from_smbus || tgt_addr == OFS_CFG_WIN)
                eff_wr = 1'b0;
        end
        tbl_written = eff_wr && (eff_addr == OFS_TBL_LOW
                                 || eff_addr == OFS_TBL_HIGH);
    end

    // ------------------------------------------------------------------
    // Merged next values for the partly writable registers.
    // ------------------------------------------------------------------
    always_comb begin
        ptr_next = merge({20'h0, ptr_reg, 2'b00}, eff_data, eff_mask);
        cap_next = merge({tbl_ofs_reg, 16'h0, arb_cap_reg},
                         eff_data, eff_mask);
        ctl_next = merge({12'h0, arb_sel_reg, 9'h0, tc_map_reg, 1'b1},
                         eff_data, eff_mask);
    end

    // ------------------------------------------------------------------
    // Read answer.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack   <= cfg_req;
            cfg_rdata <= 32'h0000_0000;
            if (cfg_req && !cfg_wr) begin
                if (!win_hit)
                    cfg_rdata <= reg_read(cfg_addr) & eff_mask;
                else if (!cfg_from_smbus && tgt_addr != OFS_CFG_WIN)
                    cfg_rdata <= reg_read(tgt_addr) & eff_mask;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sampled port state.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_reg       <= 4'h0;
            flow_pend_reg <= 1'b0;
        end else begin
            irq_reg       <= intx_state;
            flow_pend_reg <= flow_init_busy;
        end
    end

    // ------------------------------------------------------------------
    // Pointer register.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_reg <= PTR_RST;
        end else if (eff_wr && eff_addr == OFS_CFG_PTR) begin
            ptr_reg <= ptr_next[PTR_EXTENDED_REGISTER_NUMBER_MSB:PTR_REG_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Capability and control registers.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            arb_cap_reg <= ARB_CAP_RST;
            tbl_ofs_reg <= TBL_OFFSET_RST;
        end else if (eff_wr && eff_addr == OFS_RES_CAP && !cfg_lock) begin
            arb_cap_reg <= cap_next[7:0];
            tbl_ofs_reg <= cap_next[TBL_OFFSET_LSB +: 8];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tc_map_reg  <= TC_MAP_RST[7:1];
            arb_sel_reg <= ARB_SEL_RST;
            load_reg    <= 1'b0;
        end else begin
            load_reg <= 1'b0;
            if (eff_wr && eff_addr == OFS_RES_CTL) begin
                tc_map_reg  <= ctl_next[7:1];
                arb_sel_reg <= ctl_next[ARB_SEL_LSB +: 3];
                load_reg    <= eff_mask[LOAD_BIT]
                               && eff_data[LOAD_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Phase table words and their status bit.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tbl_low_reg  <= TBL_RST;
            tbl_high_reg <= TBL_RST;
        end else if (eff_wr && eff_addr == OFS_TBL_LOW) begin
            tbl_low_reg <= merge(tbl_low_reg, eff_data, eff_mask);
        end else if (eff_wr && eff_addr == OFS_TBL_HIGH) begin
            tbl_high_reg <= merge(tbl_high_reg, eff_data, eff_mask);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            tbl_pend_reg <= 1'b0;
        else if (tbl_written)
            tbl_pend_reg <= 1'b1;
        else if (load_done)
            tbl_pend_reg <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Port arbiter.
    // ------------------------------------------------------------------
    vcarb_phase_arbiter #(
        .NUM_PHASES (32),
        .EGRESS_ID  (EGRESS_ID)
    ) u_arbiter (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .table_words ({tbl_high_reg, tbl_low_reg}),
        .load_req    (load_reg),
        .load_done   (load_done),
        .arb_step    (arb_step),
        .grant_id    (arb_grant_id),
        .grant_valid (arb_grant_valid)
    );

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_ack_one_cycle: assert property (cfg_req |=> cfg_ack)
        else $error("Configuration access not answered next cycle.");
    a_ptr_fields: assert property (
        cfg_req && !cfg_wr && cfg_addr == OFS_CFG_PTR && cfg_be == 4'hF
        |=> cfg_rdata == {20'h0, $past(ptr_reg), 2'b00})
        else $error("Pointer read shows wrong bits.");
    a_self_window: assert property (
        cfg_req && !cfg_wr && win_hit && tgt_addr == OFS_CFG_WIN
        |=> cfg_rdata == 32'h0)
        else $error("Window aimed at itself did not read zero.");
    a_smbus_window: assert property (
        cfg_req && cfg_from_smbus && win_hit
        |=> cfg_rdata == 32'h0 && $stable(tbl_low_reg)
            && $stable(ptr_reg))
        else $error("SMBus window access had an effect.");
    a_header_value: assert property (
        cfg_req && !cfg_wr && cfg_addr == OFS_VC_HDR && cfg_be == 4'hF
        |=> cfg_rdata == 32'h0001_0002)
        else $error("Capability header value wrong.");
    a_ctl_fixed: assert property (
        cfg_req && !cfg_wr && cfg_addr == OFS_RES_CTL && cfg_be == 4'hF
        |=> !cfg_rdata[LOAD_BIT] && cfg_rdata[CHAN_EN_BIT]
            && cfg_rdata[26:24] == 3'h0 && cfg_rdata[0])
        else $error("Control register fixed bits wrong.");
    a_pend_set: assert property (tbl_written |=> tbl_pend_reg)
        else $error("Table write did not set pending.");
    a_pend_clear: assert property (
        load_reg ##1 (load_done && !tbl_written) |=> !tbl_pend_reg)
        else $error("Pending not cleared after load.");
    a_load_pulse: assert property (
        eff_wr && eff_addr == OFS_RES_CTL && eff_mask[LOAD_BIT]
        && eff_data[LOAD_BIT] |=> load_reg ##1 load_done)
        else $error("Load command did not reach the arbiter.");

    a_irq_read: assert property (
        cfg_req && !cfg_wr && cfg_addr == OFS_IRQ_STATE && cfg_be == 4'hF
        |=> cfg_rdata == {28'h0, $past(intx_state, 2)})
        else $error("Interrupt state read shows wrong bits.");
    a_flow_read: assert property (
        cfg_req && !cfg_wr && cfg_addr == OFS_RES_STATE && cfg_be[0]
        |=> cfg_rdata[FLOW_PEND_BIT] == $past(flow_init_busy, 2))
        else $error("Flow init pending bit wrong.");
    a_port_cap_value: assert property (
        cfg_req && !cfg_wr && cfg_addr == OFS_PORT_CAP && cfg_be == 4'hF
        |=> cfg_rdata == 32'h0000_0400)
        else $error("Port capability value wrong.");
    a_res_cap_zero: assert property (
        cfg_req && !cfg_wr && cfg_addr == OFS_RES_CAP
        |=> cfg_rdata[23:8] == 16'h0000)
        else $error("Resource capability fixed fields not zero.");
    a_lock_hold: assert property (
        cfg_lock && eff_wr && eff_addr == OFS_RES_CAP
        |=> $stable(arb_cap_reg) && $stable(tbl_ofs_reg))
        else $error("Locked capability fields changed.");
    a_ptr_self: assert property (
        win_hit && eff_wr && tgt_addr == OFS_CFG_PTR && cfg_be == 4'hF
        |=> ptr_reg == $past(cfg_wdata[PTR_EXTENDED_REGISTER_NUMBER_MSB:PTR_REG_LSB]))
        else $error("Window write did not reach the pointer.");
    a_win_bytes: assert property (
        win_hit && eff_wr && tgt_addr == OFS_TBL_LOW && cfg_be == 4'h5
        |=> tbl_low_reg[15:8] == $past(tbl_low_reg[15:8])
            && tbl_low_reg[23:16] == $past(cfg_wdata[23:16]))
        else $error("Window write ignored its byte enables.");

    c_indirect_write: cover property (eff_wr && win_hit);
    c_lock_block: cover property (cfg_lock && cfg_req && cfg_wr
                                  && cfg_addr == OFS_RES_CAP);
    c_load_done: cover property (tbl_written ##[1:20] load_done);
    c_ptr_self: cover property (win_hit && cfg_wr
                                && tgt_addr == OFS_CFG_PTR);

endmodule : vcarb_cfg_regs

// ### verification/tb_top.sv
/*
 * Self-checking bench for the port configuration slice and its arbiter.
 * Assumes vcarb_pkg and vcarb_cfg_regs are compiled before this file.
 */
`timescale 1ns/100ps
module tb_top
    import vcarb_pkg::*;
;
    // ------------------------------------------------------------------
    // Stimulus and observation signals.
    // ------------------------------------------------------------------
    logic        clk_sys        = 1'b0;
    logic        sys_rst        = 1'b1;
    logic        cfg_req        = 1'b0;
    logic        cfg_wr         = 1'b0;
    logic        cfg_from_smbus = 1'b0;
    logic [11:0] cfg_addr       = 12'h000;
    logic [3:0]  cfg_be         = 4'h0;
    logic [31:0] cfg_wdata      = 32'h0;
    logic        cfg_lock       = 1'b0;
    logic [3:0]  intx_state     = 4'h0;
    logic        flow_init_busy = 1'b0;
    logic        arb_step       = 1'b0;
    logic        cfg_ack;
    logic [31:0] cfg_rdata;
    logic [1:0]  arb_grant_id;
    logic        arb_grant_valid;
    int          n_mismatch     = 0;
    int          cmp_count      = 0;

    always #25 clk_sys = ~clk_sys;

    vcarb_cfg_regs dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_from_smbus(cfg_from_smbus),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_lock(cfg_lock),
        .intx_state(intx_state), .flow_init_busy(flow_init_busy),
        .arb_step(arb_step), .arb_grant_id(arb_grant_id),
        .arb_grant_valid(arb_grant_valid));

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic acc(input logic wr, input logic [11:0] a,
                       input logic [3:0] be, input logic [31:0] d,
                       output logic [31:0] q);
        @(negedge clk_sys);
        cfg_req = 1'b1;
        cfg_wr = wr;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge clk_sys);
        cfg_req = 1'b0;
        chk("cfg_ack", {31'h0, cfg_ack}, 32'h1);
        q = cfg_rdata;
    endtask : acc

    task automatic wr(input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, be, d, q);
    endtask : wr

    task automatic rd(input string what, input logic [11:0] a,
                      input logic [31:0] exp);
        logic [31:0] q;
        acc(1'b0, a, 4'hF, 32'h0, q);
        chk(what, q, exp);
    endtask : rd

    task automatic load_table;
        wr(OFS_RES_CTL, 4'h4, 32'h0001_0000);
        repeat (4) @(negedge clk_sys);
        rd("table_update_pending", OFS_RES_STATE, 32'h0);
        rd("load_arbiter_table", OFS_RES_CTL, 32'h8000_00FF);
    endtask : load_table

    task automatic step(input logic [1:0] id);
        @(negedge clk_sys);
        arb_step = 1'b1;
        @(negedge clk_sys);
        arb_step = 1'b0;
        chk("grant_valid", {31'h0, arb_grant_valid}, 32'h1);
        chk("grant_id", {30'h0, arb_grant_id}, {30'h0, id});
    endtask : step

    task automatic t_fixed;
        intx_state = 4'hA;
        rd("legacy_irq_state", OFS_IRQ_STATE, 32'h0000_000A);
        rd("vc_cap_header", OFS_VC_HDR, 32'h0001_0002);
        wr(OFS_PORT_CAP, 4'hF, 32'hFFFF_FFFF);
        rd("port_vc_capability_one", OFS_PORT_CAP, 32'h0000_0400);
        rd("vc_resource_capability", OFS_RES_CAP, 32'h0000_0001);
        rd("vc_resource_control", OFS_RES_CTL, 32'h8000_00FF);
        rd("unmapped", 12'h200, 32'h0);
        flow_init_busy = 1'b1;
        rd("flow_init_pending", OFS_RES_STATE, 32'h0000_0002);
        flow_init_busy = 1'b0;
    endtask : t_fixed

    task automatic t_lock;
        cfg_lock = 1'b1;
        wr(OFS_RES_CAP, 4'hF, 32'hFFFF_FFFF);
        rd("locked capability", OFS_RES_CAP, 32'h0000_0001);
        cfg_lock = 1'b0;
        wr(OFS_RES_CAP, 4'hF, 32'hFFFF_FFFF);
        rd("table_offset", OFS_RES_CAP, 32'hFF00_00FF);
        wr(OFS_RES_CTL, 4'h1, 32'h0);
        rd("traffic_class_map", OFS_RES_CTL, 32'h8000_0001);
        wr(OFS_RES_CTL, 4'h1, 32'h0000_00FE);
    endtask : t_lock

    task automatic t_window;
        wr(OFS_CFG_PTR, 4'hF, 32'hFFFF_FFFF);
        rd("indirect_cfg_pointer", OFS_CFG_PTR, 32'h0000_0FFC);
        wr(OFS_CFG_PTR, 4'hF, {20'h0, OFS_TBL_LOW});
        wr(OFS_CFG_WIN, 4'h5, 32'hFFFF_FFFF);
        rd("window write", OFS_TBL_LOW, 32'h00FF_00FF);
        rd("table_update_pending", OFS_RES_STATE, 32'h1);
        cfg_from_smbus = 1'b1;
        wr(OFS_CFG_WIN, 4'hF, 32'h0);
        rd("smbus window read", OFS_CFG_WIN, 32'h0);
        cfg_from_smbus = 1'b0;
        rd("window read", OFS_CFG_WIN, 32'h00FF_00FF);
        wr(OFS_CFG_PTR, 4'hF, {20'h0, OFS_CFG_WIN});
        rd("self window read", OFS_CFG_WIN, 32'h0);
        wr(OFS_CFG_PTR, 4'hF, {20'h0, OFS_CFG_PTR});
        wr(OFS_CFG_WIN, 4'hF, {20'h0, OFS_TBL_LOW});
        rd("pointer via window", OFS_CFG_PTR, {20'h0, OFS_TBL_LOW});
        load_table();
    endtask : t_window

    task automatic t_arbiter;
        logic [63:0] tbl;
        // Only ports B and C are loaded, so every phase is usable.
        tbl = {32'hAAAA_AAAA, 32'h9999_9999};
        wr(OFS_TBL_LOW, 4'hF, tbl[31:0]);
        rd("arb_slot_zero", OFS_TBL_LOW, tbl[31:0]);
        wr(OFS_TBL_HIGH, 4'hF, tbl[63:32]);
        rd("table word 1", OFS_TBL_HIGH, tbl[63:32]);
        load_table();
        for (int n = 0; n < 33; n++)
            step(tbl[2*(n%32) +: 2]);
        wr(OFS_TBL_LOW, 4'hF, 32'h5555_5555);
        step(tbl[3:2]);
    endtask : t_arbiter

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    initial begin
        #(50 * 5000);
        n_mismatch++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        t_fixed();
        t_lock();
        t_window();
        t_arbiter();
        end_sim();
    end
endmodule : tb_top
